// *** hdl/dms_map.vh ***
`ifndef DMS_MAP_VH
`define DMS_MAP_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define DMS_OFS_SADDR 8'h00
`define DMS_OFS_DADDR 8'h04
`define DMS_OFS_DSCR 8'h08
`define DMS_OFS_CTRLA 8'h0C
`define DMS_OFS_CTRLB 8'h10
`define DMS_OFS_CFG 8'h14
`define DMS_OFS_CMD 8'h18
`define DMS_OFS_MASK 8'h1C
`define DMS_OFS_STAT 8'h20

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DMS_CA_SRC_OFF 16
`define DMS_CA_DST_OFF 17
`define DMS_CA_DONE 31
`define DMS_CB_AUTO 31
`define DMS_CFG_SRC_RLD 8
`define DMS_CFG_DST_RLD 12
`define DMS_MSK_BTC 0
`define DMS_MSK_CHAIN_DONE_EVENT 1
`define DMS_CMD_EN 0
`define DMS_CMD_RESUME 1
`define DMS_LEN_MASK 32'h0000_FFFF
`define DMS_DONE_MASK 32'h8000_0000

// ----------------------------------------------------------------------
// descriptor layout and reset values
// ----------------------------------------------------------------------
`define DMS_DW_SADDR 3'h0
`define DMS_DW_DADDR 3'h1
`define DMS_DW_DSCR 3'h2
`define DMS_DW_CTRLA 3'h3
`define DMS_DW_CTRLB 3'h4
`define DMS_DW_LAST 3'h4
`define DMS_WB_OFS 32'h0000_000C
`define DMS_RST_WORD 32'h0000_0000
`define DMS_RST_MASK 2'h0

`endif

// *** hdl/dms_sequencer.v ***
`timescale 1ns/1ps
`include "dms_map.vh"

module dms_sequencer (
  input wire I_MCLK,
  input wire I_RESETN,
  input wire [7:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output wire [31:0] O_RDATA,
  output wire O_MEM_REQ,
  output wire O_MEM_WE,
  output wire [31:0] O_MEM_ADDR,
  output wire [31:0] O_MEM_WDATA,
  input wire I_MEM_ACK,
  input wire [31:0] I_MEM_RDATA,
  output wire O_BUF_START,
  output wire [31:0] O_BUF_SADDR,
  output wire [31:0] O_BUF_DADDR,
  output wire [15:0] O_BUF_LEN,
  input wire I_BUF_DONE,
  input wire [31:0] I_BUF_SEND,
  input wire [31:0] I_BUF_DEND,
  input wire [15:0] I_BUF_LEFT,
  output wire O_BUF_DONE_EVT,
  output wire O_CHAIN_DONE_EVT,
  output wire O_XFER_DONE,
  output wire O_BUSY,
  output wire O_STALLED
);

  localparam S_IDLE = 3'd0;
  localparam S_FETCH = 3'd1;
  localparam S_APPLY = 3'd2;
  localparam S_RUN = 3'd3;
  localparam S_WAIT = 3'd4;
  localparam S_WBACK = 3'd5;
  localparam S_EVAL = 3'd6;
  localparam S_STALL = 3'd7;

  function hit;
    input [7:0] a;
    input [7:0] o;
    begin
      hit = (a == o);
    end
  endfunction

  reg [2:0] state_q;
  reg [2:0] idx_q;
  reg [31:0] saddr_q;
  reg [31:0] daddr_q;
  reg [31:0] dscr_q;
  reg [31:0] ctla_q;
  reg [31:0] ctlb_q;
  reg [31:0] cfg_q;
  reg [1:0] mask_q;
  reg [31:0] init_sa_q;
  reg [31:0] init_da_q;
  reg [31:0] init_ca_q;
  reg [31:0] init_cb_q;
  reg [31:0] end_s_q;
  reg [31:0] end_d_q;
  reg [31:0] wb_ptr_q;
  reg chained_q;
  reg [31:0] fw_q [0:4];
  reg mem_req_q;
  reg mem_we_q;
  reg [31:0] mem_addr_q;
  reg [31:0] mem_wdata_q;
  reg buf_start_q;
  reg btc_evt_q;
  reg chain_done_event_evt_q;
  reg xfer_done_q;
  reg [31:0] rdata_q;
  reg [31:0] rd_d;
  integer i;

  // ----------------------------------------------------------------------
  // per-side address selection
  // ----------------------------------------------------------------------
  wire [31:0] ctla_src;
  wire [1:0] chain_off;
  wire [1:0] reload;
  wire [63:0] desc_addr;
  wire [63:0] cont_addr;
  wire [63:0] init_addr;
  wire [63:0] next_addr;
  wire [1:0] side_cont;
  wire auto_on;
  wire [31:0] ctla_done;
  wire [31:0] apply_ctla;
  wire [31:0] replay_ctlb;

  // descriptor bits while applying, enable-time bits while replaying
  assign ctla_src = (state_q == S_APPLY) ? fw_q[`DMS_DW_CTRLA] : init_ca_q;
  assign chain_off = {ctla_src[`DMS_CA_DST_OFF],
                      ctla_src[`DMS_CA_SRC_OFF]};
  assign reload = {cfg_q[`DMS_CFG_DST_RLD], cfg_q[`DMS_CFG_SRC_RLD]};
  assign desc_addr = {fw_q[`DMS_DW_DADDR], fw_q[`DMS_DW_SADDR]};
  assign cont_addr = {end_d_q, end_s_q};
  assign init_addr = {init_da_q, init_sa_q};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_side
      dms_side_sel u_sel (
        .i_chain_off(chain_off[g]),
        .i_reload(reload[g]),
        .i_desc_addr(desc_addr[g*32 +: 32]),
        .i_cont_addr(cont_addr[g*32 +: 32]),
        .i_init_addr(init_addr[g*32 +: 32]),
        .o_next_addr(next_addr[g*32 +: 32]),
        .o_cont(side_cont[g])
      );
    end
  endgenerate

  assign auto_on = ctlb_q[`DMS_CB_AUTO];
  // remaining length and done flag written before the word goes out
  assign ctla_done = (ctla_q & ~`DMS_LEN_MASK) | {16'h0000, I_BUF_LEFT}
                     | `DMS_DONE_MASK;
  // with repeat set on a fetched buffer the length is replayed
  assign apply_ctla = fw_q[`DMS_DW_CTRLB][`DMS_CB_AUTO] ?
    ((fw_q[`DMS_DW_CTRLA] & ~`DMS_LEN_MASK) | (init_ca_q & `DMS_LEN_MASK))
    : fw_q[`DMS_DW_CTRLA];
  // replay keeps the live repeat bit so software can stop the loop
  assign replay_ctlb = {ctlb_q[`DMS_CB_AUTO], init_cb_q[30:0]};

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always @(posedge I_MCLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      state_q <= S_IDLE;
      idx_q <= 3'h0;
      saddr_q <= `DMS_RST_WORD;
      daddr_q <= `DMS_RST_WORD;
      dscr_q <= `DMS_RST_WORD;
      ctla_q <= `DMS_RST_WORD;
      ctlb_q <= `DMS_RST_WORD;
      cfg_q <= `DMS_RST_WORD;
      mask_q <= `DMS_RST_MASK;
      init_sa_q <= `DMS_RST_WORD;
      init_da_q <= `DMS_RST_WORD;
      init_ca_q <= `DMS_RST_WORD;
      init_cb_q <= `DMS_RST_WORD;
      end_s_q <= `DMS_RST_WORD;
      end_d_q <= `DMS_RST_WORD;
      wb_ptr_q <= `DMS_RST_WORD;
      chained_q <= 1'b0;
      for (i = 0; i < 5; i = i + 1)
      begin
        fw_q[i] <= `DMS_RST_WORD;
      end
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= `DMS_RST_WORD;
      mem_wdata_q <= `DMS_RST_WORD;
      buf_start_q <= 1'b0;
      btc_evt_q <= 1'b0;
      chain_done_event_evt_q <= 1'b0;
      xfer_done_q <= 1'b0;
    end
    else
    begin
      buf_start_q <= 1'b0;
      btc_evt_q <= 1'b0;
      chain_done_event_evt_q <= 1'b0;
      xfer_done_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (I_WR && hit(I_ADDR, `DMS_OFS_CMD) && I_WDATA[`DMS_CMD_EN])
          begin
            init_sa_q <= saddr_q;
            init_da_q <= daddr_q;
            init_ca_q <= ctla_q;
            init_cb_q <= ctlb_q;
            end_s_q <= saddr_q;
            end_d_q <= daddr_q;
            if (dscr_q != `DMS_RST_WORD)
            begin
              wb_ptr_q <= dscr_q;
              mem_addr_q <= dscr_q;
              mem_req_q <= 1'b1;
              idx_q <= `DMS_DW_SADDR;
              state_q <= S_FETCH;
            end
            else
            begin
              chained_q <= 1'b0;
              state_q <= S_RUN;
            end
          end
        end
        S_FETCH:
        begin
          if (I_MEM_ACK)
          begin
            fw_q[idx_q] <= I_MEM_RDATA;
            if (idx_q == `DMS_DW_LAST)
            begin
              mem_req_q <= 1'b0;
              state_q <= S_APPLY;
            end
            else
            begin
              idx_q <= idx_q + 3'h1;
              mem_addr_q <= wb_ptr_q + {27'h000_0000, idx_q + 3'h1,
                                        2'b00};
            end
          end
        end
        S_APPLY:
        begin
          saddr_q <= next_addr[31:0];
          daddr_q <= next_addr[63:32];
          dscr_q <= fw_q[`DMS_DW_DSCR];
          ctla_q <= apply_ctla;
          ctlb_q <= fw_q[`DMS_DW_CTRLB];
          chained_q <= 1'b1;
          state_q <= S_RUN;
        end
        S_RUN:
        begin
          buf_start_q <= 1'b1;
          state_q <= S_WAIT;
        end
        S_WAIT:
        begin
          if (I_BUF_DONE)
          begin
            ctla_q <= ctla_done;
            end_s_q <= I_BUF_SEND;
            end_d_q <= I_BUF_DEND;
            if (chained_q)
            begin
              mem_req_q <= 1'b1;
              mem_we_q <= 1'b1;
              mem_addr_q <= wb_ptr_q + `DMS_WB_OFS;
              mem_wdata_q <= ctla_done;
              state_q <= S_WBACK;
            end
            else
            begin
              state_q <= S_EVAL;
            end
          end
        end
        S_WBACK:
        begin
          if (I_MEM_ACK)
          begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            state_q <= S_EVAL;
          end
        end
        S_EVAL:
        begin
          btc_evt_q <= mask_q[`DMS_MSK_BTC];
          if (!auto_on && dscr_q == `DMS_RST_WORD)
          begin
            chain_done_event_evt_q <= mask_q[`DMS_MSK_CHAIN_DONE_EVENT];
            xfer_done_q <= 1'b1;
            state_q <= S_IDLE;
          end
          else if (dscr_q != `DMS_RST_WORD)
          begin
            wb_ptr_q <= dscr_q;
            mem_addr_q <= dscr_q;
            mem_req_q <= 1'b1;
            idx_q <= `DMS_DW_SADDR;
            state_q <= S_FETCH;
          end
          else
          begin
            saddr_q <= next_addr[31:0];
            daddr_q <= next_addr[63:32];
            ctla_q <= init_ca_q;
            ctlb_q <= replay_ctlb;
            chained_q <= 1'b0;
            if ((&side_cont) && mask_q[`DMS_MSK_BTC])
            begin
              state_q <= S_STALL;
            end
            else
            begin
              state_q <= S_RUN;
            end
          end
        end
        S_STALL:
        begin
          if (I_WR && hit(I_ADDR, `DMS_OFS_CMD)
              && I_WDATA[`DMS_CMD_RESUME])
          begin
            state_q <= S_RUN;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase

      // software writes; channel fields other than CTRLB and the mask are locked while busy
      if (I_WR)
      begin
        if (state_q == S_IDLE)
        begin
          if (hit(I_ADDR, `DMS_OFS_SADDR))
            saddr_q <= I_WDATA;
          if (hit(I_ADDR, `DMS_OFS_DADDR))
            daddr_q <= I_WDATA;
          if (hit(I_ADDR, `DMS_OFS_DSCR))
            dscr_q <= I_WDATA;
          if (hit(I_ADDR, `DMS_OFS_CTRLA))
            ctla_q <= I_WDATA;
          if (hit(I_ADDR, `DMS_OFS_CFG))
            cfg_q <= I_WDATA;
        end
        if (hit(I_ADDR, `DMS_OFS_CTRLB))
          ctlb_q <= I_WDATA;
        if (hit(I_ADDR, `DMS_OFS_MASK))
          mask_q <= I_WDATA[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  always @*
  begin
    rd_d = `DMS_RST_WORD;
    case (I_ADDR)
      `DMS_OFS_SADDR: rd_d = saddr_q;
      `DMS_OFS_DADDR: rd_d = daddr_q;
      `DMS_OFS_DSCR: rd_d = dscr_q;
      `DMS_OFS_CTRLA: rd_d = ctla_q;
      `DMS_OFS_CTRLB: rd_d = ctlb_q;
      `DMS_OFS_CFG: rd_d = cfg_q;
      `DMS_OFS_CMD: rd_d = {31'h0000_0000, state_q != S_IDLE};
      `DMS_OFS_MASK: rd_d = {30'h0000_0000, mask_q};
      `DMS_OFS_STAT: rd_d = {27'h000_0000, chained_q, state_q == S_STALL,
                             state_q};
      default: rd_d = `DMS_RST_WORD;
    endcase
  end

  always @(posedge I_MCLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      rdata_q <= `DMS_RST_WORD;
    end
    else
    begin
      rdata_q <= I_RD ? rd_d : `DMS_RST_WORD;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_MEM_REQ = mem_req_q;
  assign O_MEM_WE = mem_we_q;
  assign O_MEM_ADDR = mem_addr_q;
  assign O_MEM_WDATA = mem_wdata_q;
  assign O_BUF_START = buf_start_q;
  assign O_BUF_SADDR = saddr_q;
  assign O_BUF_DADDR = daddr_q;
  assign O_BUF_LEN = ctla_q[15:0];
  assign O_BUF_DONE_EVT = btc_evt_q;
  assign O_CHAIN_DONE_EVT = chain_done_event_evt_q;
  assign O_XFER_DONE = xfer_done_q;
  assign O_BUSY = (state_q != S_IDLE);
  assign O_STALLED = (state_q == S_STALL);

endmodule // dms_sequencer

// *** hdl/dms_side_sel.v ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// next start address for one side of the channel
// ----------------------------------------------------------------------
module dms_side_sel (
  input wire i_chain_off,
  input wire i_reload,
  input wire [31:0] i_desc_addr,
  input wire [31:0] i_cont_addr,
  input wire [31:0] i_init_addr,
  output reg [31:0] o_next_addr,
  output wire o_cont
);

  assign o_cont = i_chain_off & ~i_reload;

  always @*
  begin
    if (!i_chain_off)
    begin
      o_next_addr = i_desc_addr;
    end
    else if (i_reload)
    begin
      o_next_addr = i_init_addr;
    end
    else
    begin
      o_next_addr = i_cont_addr;
    end
  end

endmodule // dms_side_sel

// *** testbench/dms_mem_model.sv ***
`timescale 1ns/1ps

// ----
// descriptor memory with wait states
// ----
module dms_mem_model (
  input logic i_clk,
  input logic i_resetn,
  input logic i_req,
  input logic i_we,
  input logic [31:0] i_addr,
  input logic [31:0] i_wdata,
  input logic [1:0] i_wait,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:63];
  logic [1:0] cnt_q;

  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      o_ack <= 1'b0;
      cnt_q <= 2'h0;
      o_rdata <= 32'h5A5A_A5A5;
    end
    else if (o_ack)
    begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_we) mem[i_addr[7:2]] <= i_wdata;
    end
    else if (i_req && cnt_q == i_wait)
    begin
      o_ack <= 1'b1;
      cnt_q <= 2'h0;
      o_rdata <= i_we ? ~o_rdata : mem[i_addr[7:2]];
    end
    else
    begin
      // no stale data outside an ack
      cnt_q <= i_req ? cnt_q + 2'h1 : 2'h0;
      o_rdata <= ~o_rdata;
    end
endmodule // dms_mem_model

// *** testbench/dms_seq_chk.sv ***
`timescale 1ns/1ps
`include "dms_map.vh"

// ----
// sequencer port checks
// ----
module dms_seq_chk (
  input logic I_MCLK,
  input logic I_RESETN,
  input logic [7:0] I_ADDR,
  input logic [31:0] I_WDATA,
  input logic I_WR,
  input logic O_MEM_REQ,
  input logic O_MEM_WE,
  input logic [31:0] O_MEM_ADDR,
  input logic [31:0] O_MEM_WDATA,
  input logic I_MEM_ACK,
  input logic O_BUF_START,
  input logic O_BUF_DONE_EVT,
  input logic O_CHAIN_DONE_EVT,
  input logic O_XFER_DONE,
  input logic O_BUSY,
  input logic O_STALLED
);
  logic [2:0] rd_q;
  logic [31:0] base_q;
  logic [1:0] msk_q;

  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);

  // read count and base of the running fetch
  always @(posedge I_MCLK or negedge I_RESETN)
    if (!I_RESETN)
    begin
      rd_q <= 3'h0;
      base_q <= 32'h0;
      msk_q <= 2'h0;
    end
    else
    begin
      if (!O_MEM_REQ) rd_q <= 3'h0;
      else if (I_MEM_ACK && !O_MEM_WE) rd_q <= rd_q + 3'h1;
      if (O_MEM_REQ && !O_MEM_WE && rd_q == 3'h0) base_q <= O_MEM_ADDR;
      if (I_WR && I_ADDR == `DMS_OFS_MASK) msk_q <= I_WDATA[1:0];
    end

  fetch_step_a: assert property (
    I_MEM_ACK && O_MEM_REQ && !O_MEM_WE ##1 O_MEM_REQ
    |-> O_MEM_ADDR == $past(O_MEM_ADDR) + 32'h4)
    else $error("fetch address not consecutive");
  req_hold_a: assert property (
    O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM_ADDR)
    && $stable(O_MEM_WE) && $stable(O_MEM_WDATA))
    else $error("memory request changed before ack");
  five_words_a: assert property (
    $fell(O_MEM_REQ) && !$past(O_MEM_WE) |-> rd_q == 3'h5)
    else $error("fetch did not read five words");
  wb_place_a: assert property (
    O_MEM_REQ && O_MEM_WE |-> O_MEM_ADDR == base_q + 32'hC)
    else $error("write back at wrong address");
  done_flag_a: assert property (
    O_MEM_REQ && O_MEM_WE |-> O_MEM_WDATA[31])
    else $error("write back without done flag");
  start_fetch_a: assert property (
    $fell(O_MEM_REQ) && !$past(O_MEM_WE) |-> ##[1:4] O_BUF_START)
    else $error("no buffer start after fetch");
  buf_evt_a: assert property (O_BUF_DONE_EVT |-> msk_q[0])
    else $error("buffer event while masked");
  chain_evt_a: assert property (
    O_CHAIN_DONE_EVT |-> msk_q[1] && O_XFER_DONE)
    else $error("chain event out of place");
  xfer_off_a: assert property (O_XFER_DONE |-> ##[0:1] !O_BUSY)
    else $error("channel still busy after end");
  stall_hold_a: assert property (
    O_STALLED |-> O_BUSY && !O_BUF_START && !O_MEM_REQ)
    else $error("activity while stalled");
endmodule // dms_seq_chk

bind dms_sequencer dms_seq_chk i_dms_seq_chk (.I_MCLK(I_MCLK),
  .I_RESETN(I_RESETN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE), .O_MEM_ADDR(O_MEM_ADDR),
  .O_MEM_WDATA(O_MEM_WDATA), .I_MEM_ACK(I_MEM_ACK),
  .O_BUF_START(O_BUF_START), .O_BUF_DONE_EVT(O_BUF_DONE_EVT),
  .O_CHAIN_DONE_EVT(O_CHAIN_DONE_EVT), .O_XFER_DONE(O_XFER_DONE),
  .O_BUSY(O_BUSY), .O_STALLED(O_STALLED));

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`include "dms_map.vh"

module tb;
  logic I_MCLK = 0, I_RESETN = 0, I_WR = 0, I_RD = 0, I_BUF_DONE = 0;
  logic [7:0] I_ADDR = 0;
  logic [31:0] I_WDATA = 0, I_BUF_SEND = 0, I_BUF_DEND = 0, I_MEM_RDATA;
  logic [31:0] O_RDATA, O_MEM_ADDR, O_MEM_WDATA, O_BUF_SADDR, O_BUF_DADDR;
  logic [15:0] I_BUF_LEFT = 0, O_BUF_LEN;
  logic I_MEM_ACK, O_MEM_REQ, O_MEM_WE, O_BUF_START, O_BUF_DONE_EVT;
  logic O_CHAIN_DONE_EVT, O_XFER_DONE, O_BUSY, O_STALLED;
  logic [31:0] sa [0:7], da [0:7], off;
  logic [15:0] bl [0:7];
  logic [1:0] mwait = 0, ec = 0;
  int nbuf = 0, nbe = 0, nce = 0, nxd = 0, num_errors = 0, checks_done = 0;
  int k;
  // cfg, chain-off code, sa0, da0, sa1, da1
  logic [15:0] tab [0:4][0:5] = '{
    '{16'h0, 16'h0, 16'h100, 16'h200, 16'h300, 16'h400},
    '{16'h0, 16'h2, 16'h100, 16'h500, 16'h300, 16'h508},
    '{16'h1000, 16'h2, 16'h100, 16'h500, 16'h300, 16'h500},
    '{16'h0, 16'h1, 16'h700, 16'h200, 16'h708, 16'h400},
    '{16'h0100, 16'h1, 16'h700, 16'h200, 16'h700, 16'h400}};

  always #10 I_MCLK = ~I_MCLK;

  dms_sequencer i_dms_sequencer (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE),
    .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA),
    .I_MEM_ACK(I_MEM_ACK), .I_MEM_RDATA(I_MEM_RDATA),
    .O_BUF_START(O_BUF_START), .O_BUF_SADDR(O_BUF_SADDR),
    .O_BUF_DADDR(O_BUF_DADDR), .O_BUF_LEN(O_BUF_LEN),
    .I_BUF_DONE(I_BUF_DONE), .I_BUF_SEND(I_BUF_SEND),
    .I_BUF_DEND(I_BUF_DEND), .I_BUF_LEFT(I_BUF_LEFT),
    .O_BUF_DONE_EVT(O_BUF_DONE_EVT), .O_CHAIN_DONE_EVT(O_CHAIN_DONE_EVT),
    .O_XFER_DONE(O_XFER_DONE), .O_BUSY(O_BUSY), .O_STALLED(O_STALLED));
  dms_mem_model i_dms_mem_model (.i_clk(I_MCLK), .i_resetn(I_RESETN),
    .i_req(O_MEM_REQ), .i_we(O_MEM_WE), .i_addr(O_MEM_ADDR),
    .i_wdata(O_MEM_WDATA), .i_wait(mwait), .o_ack(I_MEM_ACK),
    .o_rdata(I_MEM_RDATA));

  // ----
  // buffer engine: done three cycles after start
  // ----
  always @(posedge I_MCLK)
  begin
    I_BUF_DONE <= 1'b0;
    if (ec != 2'h0) ec <= ec - 2'h1;
    if (ec == 2'h1)
    begin
      I_BUF_DONE <= 1'b1;
      I_BUF_SEND <= sa[nbuf-1] + bl[nbuf-1];
      I_BUF_DEND <= da[nbuf-1] + bl[nbuf-1];
    end
    if (O_BUF_START === 1'b1)
    begin
      sa[nbuf] <= O_BUF_SADDR;
      da[nbuf] <= O_BUF_DADDR;
      bl[nbuf] <= O_BUF_LEN;
      nbuf <= nbuf + 1;
      ec <= 2'h3;
    end
    // step only on a pulse so the clear in prog is not undone
    if (O_BUF_DONE_EVT === 1'b1) nbe <= nbe + 1;
    if (O_CHAIN_DONE_EVT === 1'b1) nce <= nce + 1;
    if (O_XFER_DONE === 1'b1) nxd <= nxd + 1;
  end

  // ----
  // bus and check tasks
  // ----
  task summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_MCLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge I_MCLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    @(negedge I_MCLK);
    chk(O_RDATA, e);
  endtask

  // 0: idle, 1: n buffers started, 2: stalled
  task waitc(input int s, input int n);
    int i;
    bit ok;
    ok = 0;
    for (i = 0; i < 600 && !ok; i++)
    begin
      @(negedge I_MCLK);
      ok = s == 0 ? O_BUSY === 1'b0 : s == 1 ? nbuf >= n : O_STALLED === 1;
    end
    // let the end-of-transfer pulses reach the counters
    if (ok && s == 0) repeat (2) @(negedge I_MCLK);
    if (!ok)
    begin
      num_errors++;
      summarize();
    end
  endtask

  task prog(input logic [31:0] s, d, p, a, b, c, m);
    wr(`DMS_OFS_SADDR, s);
    wr(`DMS_OFS_DADDR, d);
    wr(`DMS_OFS_DSCR, p);
    wr(`DMS_OFS_CTRLA, a);
    wr(`DMS_OFS_CTRLB, b);
    wr(`DMS_OFS_CFG, c);
    wr(`DMS_OFS_MASK, m);
    nbuf = 0;
    nbe = 0;
    nce = 0;
    nxd = 0;
    wr(`DMS_OFS_CMD, 32'h1);
  endtask

  task ldesc(input int w, input logic [31:0] s, d, p, a);
    i_dms_mem_model.mem[w] = s;
    i_dms_mem_model.mem[w+1] = d;
    i_dms_mem_model.mem[w+2] = p;
    i_dms_mem_model.mem[w+3] = a;
    i_dms_mem_model.mem[w+4] = 32'h0;
  endtask

  task bchk(input int b, input logic [31:0] s, d, l);
    chk(sa[b], s);
    chk(da[b], d);
    chk({16'h0, bl[b]}, l);
  endtask

  // ----
  // test sequence
  // ----
  initial
  begin
    repeat (6) @(posedge I_MCLK);
    I_RESETN <= 1'b1;
    rd(`DMS_OFS_STAT, 32'h0);
    rd(`DMS_OFS_MASK, 32'h0);
    rd(8'h3C, 32'h0);
    $display("reset test done");
    prog(32'h1000, 32'h2000, 32'h0, 32'h10, 32'h0, 32'h0, 32'h3);
    waitc(0, 0);
    bchk(0, 32'h1000, 32'h2000, 32'h10);
    chk(nbuf + nbe + nce + nxd, 4);
    $display("single buffer test done");
    for (k = 0; k < 5; k++)
    begin
      mwait = k[1:0];
      off = {tab[k][1], 16'h0};
      ldesc(16, 32'h100, 32'h200, 32'h80, off | 32'h8);
      ldesc(32, 32'h300, 32'h400, 32'h0, off | 32'h4);
      prog(32'h700, 32'h500, 32'h40, 32'h0, 32'h0, tab[k][0], 32'h1);
      waitc(0, 0);
      bchk(0, tab[k][2], tab[k][3], 32'h8);
      bchk(1, tab[k][4], tab[k][5], 32'h4);
      chk(i_dms_mem_model.mem[19], off | 32'h8000_0000);
      chk(i_dms_mem_model.mem[35], off | 32'h8000_0000);
      chk(nbe + 4 * nce + 8 * nxd, 10);
      $display("chain row %0d test done", k);
    end
    mwait = 2'h0;
    prog(32'h600, 32'h800, 32'h0, 32'h0003_0006, 32'h8000_0000, 32'h1100,
      32'h1);
    waitc(1, 2);
    wr(`DMS_OFS_CTRLB, 32'h0);
    waitc(0, 0);
    bchk(1, 32'h600, 32'h800, 32'h6);
    chk(nbuf, 2);
    $display("replay test done");
    prog(32'h600, 32'h800, 32'h0, 32'h0003_0006, 32'h8000_0000, 32'h0,
      32'h1);
    waitc(2, 0);
    chk(nbuf, 1);
    rd(`DMS_OFS_STAT, 32'h0000_000F);
    wr(`DMS_OFS_CTRLB, 32'h0);
    wr(`DMS_OFS_CMD, 32'h2);
    waitc(0, 0);
    bchk(1, 32'h606, 32'h806, 32'h6);
    chk(nbe, 2);
    $display("stall test done");
    summarize();
  end
endmodule // tb
